//--- logic/kpi_pkg.sv
// Purpose: Constants shared by the keypad pin interrupt block
// Assumes: Avalon-MM register slave with 32-bit data, one word per register
// Notes: Register offsets are byte addresses
package kpi_pkg;
   // ---------------------------------------------------------------
   // Geometry
   // ---------------------------------------------------------------
   localparam int unsigned PIN_COUNT = 8;
   localparam int unsigned ADDR_W = 4;
   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [3:0] STATUS_CONTROL_OFS = 4'h0;
   localparam logic [3:0] PIN_ENABLE_OFS = 4'h4;
   localparam logic [3:0] EDGE_SELECT_OFS = 4'h8;
   // ---------------------------------------------------------------
   // Status and control fields
   // ---------------------------------------------------------------
   localparam int unsigned SENSE_MODE_BIT = 0;
   localparam int unsigned IRQ_ENABLE_BIT = 1;
   localparam int unsigned FLAG_ACK_BIT = 2;
   localparam int unsigned DETECT_FLAG_BIT = 3;
   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] STATUS_CONTROL_RST = 8'h00;
   localparam logic [7:0] PIN_ENABLE_RST = 8'h00;
   localparam logic [7:0] EDGE_SELECT_RST = 8'h00;
   // Answer returned for an unmapped address
   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage

//--- logic/kpi_keypad_irq.sv
// Purpose: Keypad pin interrupt unit, eight enabled pins, edge or edge+level
// Assumes: Pins are asynchronous; all logic on clk; Avalon-MM slave
// Notes: Answers every access one cycle after it is presented
//
// Overview of operation
// - Status/control bits 7:4 always read zero.
// - Bit 3 is the detect flag; writes do not change it.
// - Bit 2 write-one acknowledges the flag; always reads zero.
// - Bit 1 enables the interrupt request.
// - Bit 0 selects edge-only (0) or edge-and-level (1) sensing.
// - Pin enable bits choose sources; disabled pins are ignored.
// - Polarity bits: 0 falling/low, 1 rising/high.
// - Falling edge: sampled high one cycle, low the next.
// - Rising edge: sampled low one cycle, high the next.
// - Edges re-arm only after all enabled pins are deasserted.
// - A valid edge sets the flag until acknowledged.
// - Flag set with interrupt enabled raises the request.
// - Edge-and-level mode: asserted level also sets the flag.
// - Edge-and-level mode: acknowledge clears only when all pins deasserted.
// - Polarity bit selects pull-up (0) or pull-down (1) when pull enabled.
// - Eight pins, each with its own enable and polarity.
// - Low-retention stop reset puts the block in reset state.
// - Enabled pin event with interrupt enabled wakes the processor.
`timescale 1ns/1ps
module kpi_keypad_irq (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Avalon-MM slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Keypad pins and pad control
   input wire logic [7:0] wake_input_pins,
   input wire logic [7:0] port_pull_enable,
   output logic [7:0] pull_up_en,
   output logic [7:0] pull_down_en,
   // Processor side
   output logic irq,
   output logic wake_req
);
   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [7:0] meta_ff;
   logic [7:0] pin_sync_ff;
   logic [7:0] pin_prev_ff;
   logic sense_mode_ff;
   logic irq_enable_ff;
   logic detect_flag_ff;
   logic armed_ff;
   logic [7:0] pin_enable_ff;
   logic [7:0] polarity_ff;
   logic ack_done_ff;
   logic [31:0] readdata_ff;
   logic irq_ff;
   logic wake_ff;

   logic req;
   logic req_any;
   logic wr_sc;
   logic flag_ack;
   logic [7:0] asserted_now;
   logic [7:0] asserted_prev;
   logic any_asserted;
   logic edge_seen;
   logic level_seen;
   logic set_flag;
   logic [31:0] nxt_readdata;

   // ---------------------------------------------------------------
   // Pin synchroniser
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff <= 8'h00;
         pin_sync_ff <= 8'h00;
         pin_prev_ff <= 8'h00;
      end else begin
         meta_ff <= wake_input_pins;
         pin_sync_ff <= meta_ff;
         pin_prev_ff <= pin_sync_ff;
      end
   end

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   // One wait cycle per access keeps read data registered
   assign req_any = avs_read | avs_write;
   assign req = req_any & ack_done_ff;
   assign avs_waitrequest = req_any & ~ack_done_ff;
   assign avs_readdata = readdata_ff;
   assign wr_sc = req & avs_write & (avs_address == kpi_pkg::STATUS_CONTROL_OFS)
      & avs_byteenable[0];
   assign flag_ack = wr_sc & avs_writedata[kpi_pkg::FLAG_ACK_BIT];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_done_ff <= 1'b0;
      end else begin
         ack_done_ff <= req_any & ~ack_done_ff;
      end
   end

   // ---------------------------------------------------------------
   // Control registers
   // ---------------------------------------------------------------
   // Reset covers wake from low-retention stop, which arrives as rst_n
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sense_mode_ff <= kpi_pkg::STATUS_CONTROL_RST[kpi_pkg::SENSE_MODE_BIT];
         irq_enable_ff <= kpi_pkg::STATUS_CONTROL_RST[kpi_pkg::IRQ_ENABLE_BIT];
         pin_enable_ff <= kpi_pkg::PIN_ENABLE_RST;
         polarity_ff <= kpi_pkg::EDGE_SELECT_RST;
      end else if (req && avs_write && avs_byteenable[0]) begin
         if (avs_address == kpi_pkg::STATUS_CONTROL_OFS) begin
            sense_mode_ff <= avs_writedata[kpi_pkg::SENSE_MODE_BIT];
            irq_enable_ff <= avs_writedata[kpi_pkg::IRQ_ENABLE_BIT];
         end else if (avs_address == kpi_pkg::PIN_ENABLE_OFS) begin
            pin_enable_ff <= avs_writedata[7:0];
         end else if (avs_address == kpi_pkg::EDGE_SELECT_OFS) begin
            polarity_ff <= avs_writedata[7:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // Detection
   // ---------------------------------------------------------------
   // A pin is asserted when its sampled level equals its polarity bit
   assign asserted_now = ~(pin_sync_ff ^ polarity_ff) & pin_enable_ff;
   assign asserted_prev = ~(pin_prev_ff ^ polarity_ff) & pin_enable_ff;
   assign any_asserted = |asserted_now;
   assign edge_seen = armed_ff & |(asserted_now & ~asserted_prev);
   assign level_seen = sense_mode_ff & any_asserted;
   assign set_flag = edge_seen | level_seen;

   // Re-arm only once every enabled pin sits at its deasserted level
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         armed_ff <= 1'b0;
      end else if (!any_asserted) begin
         armed_ff <= 1'b1;
      end else if (edge_seen) begin
         armed_ff <= 1'b0;
      end
   end

   // Set wins over acknowledge in the same cycle; level mode blocks clear while an enabled pin is asserted
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         detect_flag_ff <= 1'b0;
      end else if (set_flag) begin
         detect_flag_ff <= 1'b1;
      end else if (flag_ack && !(sense_mode_ff && any_asserted)) begin
         detect_flag_ff <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Request and wake outputs
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_ff <= 1'b0;
         wake_ff <= 1'b0;
      end else begin
         irq_ff <= detect_flag_ff & irq_enable_ff;
         wake_ff <= irq_enable_ff & (detect_flag_ff | set_flag);
      end
   end
   assign irq = irq_ff;
   assign wake_req = wake_ff;

   // ---------------------------------------------------------------
   // Pad resistor direction
   // ---------------------------------------------------------------
   // Pull direction follows polarity for every pin whose pull is enabled, keypad input or not
   always_comb begin
      pull_up_en = port_pull_enable & ~polarity_ff;
      pull_down_en = port_pull_enable & polarity_ff;
   end

   // ---------------------------------------------------------------
   // Read data
   // ---------------------------------------------------------------
   always_comb begin
      nxt_readdata = kpi_pkg::UNMAPPED_READ;
      if (avs_address == kpi_pkg::STATUS_CONTROL_OFS) begin
         nxt_readdata[kpi_pkg::DETECT_FLAG_BIT] = detect_flag_ff;
         nxt_readdata[kpi_pkg::IRQ_ENABLE_BIT] = irq_enable_ff;
         nxt_readdata[kpi_pkg::SENSE_MODE_BIT] = sense_mode_ff;
      end else if (avs_address == kpi_pkg::PIN_ENABLE_OFS) begin
         nxt_readdata[7:0] = pin_enable_ff;
      end else if (avs_address == kpi_pkg::EDGE_SELECT_OFS) begin
         nxt_readdata[7:0] = polarity_ff;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         readdata_ff <= 32'h0000_0000;
      end else if (avs_read && !ack_done_ff) begin
         readdata_ff <= nxt_readdata;
      end
   end
endmodule

//--- tb/kpi_keys.sv
// Purpose: Key switch model driving the wake pins
// Assumes: A pressed key shorts its pin to the level opposite its pull
// Notes: An open key without pull floats and, unless slow, is shown as a toggling level
`timescale 1ns/1ps
module kpi_keys (
   // Control from the bench
   input wire logic clk,
   input wire logic slow,
   input wire logic [7:0] press,
   // Pads
   input wire logic [7:0] pull_up_en,
   input wire logic [7:0] pull_down_en,
   output logic [7:0] pins
);
   logic [1:0] dly = 2'h0;
   logic tog = 1'b0;
   initial pins = 8'hff;
   // Slow keys move only every fourth cycle, like a sluggish contact
   always @(posedge clk) begin
      tog <= ~tog;
      dly <= slow ? dly + 2'h1 : 2'h0;
      for (int i = 0; i < 8; i++) begin
         if (dly == 2'h0) pins[i] <= press[i] ? pull_down_en[i] :
            (pull_up_en[i] | (~pull_down_en[i] & tog));
      end
   end
endmodule

//--- tb/kpi_sva.sv
// Purpose: Port-level checks for the keypad pin interrupt block
// Assumes: One clock domain, reset active low
// Notes: Bound to every instance of the block
`timescale 1ns/1ps
module kpi_sva (
   // Clock, reset and bus
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // Pads and processor
   input wire logic [7:0] port_pull_enable,
   input wire logic [7:0] pull_up_en,
   input wire logic [7:0] pull_down_en,
   input wire logic irq,
   input wire logic wake_req
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire logic rd = avs_read && !avs_waitrequest;
   wire logic wr = avs_write && !avs_waitrequest;
   wire logic sc = avs_address == kpi_pkg::STATUS_CONTROL_OFS;
   property p_hi; rd |-> avs_readdata[31:8] == 24'h0; endproperty
   a_hi: assert property (p_hi) else $error("upper read bits set");
   property p_rsv; rd && sc |-> avs_readdata[7:4] == 4'h0; endproperty
   a_rsv: assert property (p_rsv) else $error("status bits 7:4 set");
   property p_ack; rd && sc |-> !avs_readdata[2]; endproperty
   a_ack: assert property (p_ack) else $error("acknowledge bit read as 1");
   property p_psum; (pull_up_en | pull_down_en) == port_pull_enable; endproperty
   a_psum: assert property (p_psum) else $error("pull enables lost");
   property p_pex; (pull_up_en & pull_down_en) == 8'h00; endproperty
   a_pex: assert property (p_pex) else $error("pull up and down together");
   property p_mask; wr && sc && !avs_writedata[1] |-> ##2 !irq; endproperty
   a_mask: assert property (p_mask) else $error("request while masked");
   property p_wake; irq |-> wake_req; endproperty
   a_wake: assert property (p_wake) else $error("request without wake");
   property p_rst; $rose(rst_n) |-> !irq && !wake_req; endproperty
   a_rst: assert property (p_rst) else $error("request out of reset");
   c_rd: cover property (rd && sc);
   c_irq: cover property ($rose(irq));
   c_ack: cover property (wr && sc && avs_writedata[2]);
endmodule
bind kpi_keypad_irq kpi_sva sva_u (.clk, .rst_n, .avs_address, .avs_read, .avs_write,
   .avs_writedata, .avs_readdata, .avs_waitrequest, .port_pull_enable, .pull_up_en,
   .pull_down_en, .irq, .wake_req);

//--- tb/testbench.sv
// Purpose: Self-checking bench for the keypad pin interrupt block
// Assumes: Keys released leave every enabled pin deasserted
// Notes: Flag expectations come from a software model of the detection
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, slow = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
   logic avs_waitrequest, irq, wake_req;
   logic [7:0] wake_input_pins, pull_up_en, pull_down_en, press = 8'h00;
   logic [7:0] port_pull_enable = 8'hff;
   int n_errors = 0, cmp_count = 0, seed = 7058;
   int m_pe, m_pol, m_mode, m_ie, m_flag, m_prev, i, j;
   localparam logic [3:0] sc_a = kpi_pkg::STATUS_CONTROL_OFS;
   localparam logic [3:0] pe_a = kpi_pkg::PIN_ENABLE_OFS;
   localparam logic [3:0] es_a = kpi_pkg::EDGE_SELECT_OFS;
   always #2 clk = ~clk;
   kpi_keypad_irq dut_u (.clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable(4'h1), .avs_readdata, .avs_waitrequest, .wake_input_pins,
      .port_pull_enable, .pull_up_en, .pull_down_en, .irq, .wake_req);
   kpi_keys keys_u (.clk, .slow, .press, .pull_up_en, .pull_down_en, .pins(wake_input_pins));
   task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
      logic w;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(negedge clk);
         w = avs_waitrequest;
         q = avs_readdata;
         @(posedge clk);
      end while (w !== 1'b0);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic sc_chk();
      bus(1'b0, sc_a, 8'h00);
      chk(q, 32'(m_flag * 8 + m_ie * 2 + m_mode));
      chk({31'h0, irq}, 32'(m_flag & m_ie));
      chk({31'h0, wake_req}, 32'(m_flag & m_ie));
   endtask
   task automatic step(input logic [7:0] p);
      int a;
      press <= p;
      repeat (8) @(posedge clk);
      a = p & m_pe;
      if (a != 0 && (m_prev == 0 || m_mode != 0)) m_flag = 1;
      m_prev = a;
      sc_chk();
   endtask
   task automatic ack();
      bus(1'b1, sc_a, 8'(4 + m_ie * 2 + m_mode));
      if (m_mode == 0 || m_prev == 0) m_flag = 0;
      sc_chk();
   endtask
   task automatic complete_run();
      $display("comparisons %0d errors %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #100000;
      n_errors++;
      complete_run();
   end
   initial begin
      {m_pe, m_pol, m_mode, m_ie, m_flag, m_prev} = '0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      bus(1'b0, 4'hc, 8'h00);
      chk(q, 32'h0);
      bus(1'b0, pe_a, 8'h00);
      chk(q, 32'h0);
      bus(1'b0, es_a, 8'h00);
      chk(q, 32'h0);
      sc_chk();
      m_pol = $random(seed) & 255;
      bus(1'b1, es_a, 8'(m_pol));
      port_pull_enable <= 8'($random(seed));
      @(posedge clk);
      chk({pull_up_en, pull_down_en}, {port_pull_enable & ~8'(m_pol), port_pull_enable & 8'(m_pol)});
      bus(1'b0, es_a, 8'h00);
      chk(q, 32'(m_pol));
      port_pull_enable <= 8'hff;
      bus(1'b1, sc_a, 8'hff);
      {m_ie, m_mode} = {1, 1};
      sc_chk();
      for (i = 0; i < 24; i++) begin
         step(8'h00);
         {m_ie, m_mode, m_pol, m_pe} = {0, $random(seed) & 1, $random(seed) & 255, $random(seed) & 255};
         slow <= 1'($random(seed));
         bus(1'b1, sc_a, 8'(m_mode));
         bus(1'b1, es_a, 8'(m_pol));
         bus(1'b1, pe_a, 8'(m_pe));
         // Let slow keys and the synchroniser settle to the new pulls first
         repeat (8) @(posedge clk);
         ack();
         m_ie = $random(seed) & 1;
         bus(1'b1, sc_a, 8'(m_ie * 2 + m_mode));
         for (j = 0; j < 5; j++) begin
            step(8'($random(seed)));
            if (j == 2) ack();
         end
      end
      complete_run();
   end
endmodule
